// ==== common/tm_cfg.svh ====
// Purpose: Constants for the thermal monitor and alert control block
// Assumes: 20 MHz system clock
// Notes: Times kept in ms, cycle counts derived from them
`ifndef TM_CFG_SVH
`define TM_CFG_SVH

`define TM_CLK_HZ 20000000
`define TM_CONV_PERIOD_MS 100
`define TM_CONV_TIME_MS 10
`define TM_BUS_TIMEOUT_MS 50
`define TM_CONV_PERIOD_CYC (`TM_CONV_PERIOD_MS * (`TM_CLK_HZ / 1000))
`define TM_CONV_TIME_CYC (`TM_CONV_TIME_MS * (`TM_CLK_HZ / 1000))
`define TM_BUS_TIMEOUT_CYC (`TM_BUS_TIMEOUT_MS * (`TM_CLK_HZ / 1000))

`define TM_ADDR_FIXED 4'h9
`define TM_PTR_TEMP 2'h0
`define TM_PTR_SET 2'h1
`define TM_PTR_HYST 2'h2
`define TM_PTR_OS 2'h3

`define TM_SET_RST 8'h00
`define TM_HYST_RST 16'h4b00
`define TM_OS_RST 16'h5000

`define TM_SET_SHUTDOWN 0
`define TM_SET_STYLE 1
`define TM_SET_POL 2
`define TM_SET_QUEUE_LO 3
`define TM_SET_QUEUE_HI 4

`endif

// ==== common/tm_pkg.sv ====
// Purpose: Types for the thermal monitor and alert control block
// Assumes: Constants come from tm_cfg.svh
// Notes: None
package tm_pkg;
   typedef enum {
      TM_IDLE, TM_ADDR, TM_ACK_ADDR, TM_WR_PTR, TM_ACK_PTR,
      TM_WR_DATA, TM_ACK_WR, TM_RD_DATA, TM_RD_ACK
   } tm_bus_state_t;
   typedef logic [1:0] tm_ptr_t;
endpackage : tm_pkg

// ==== logic/tm_thermal_monitor.sv ====
// Purpose: Conversion scheduling, limit compare, alert and two-wire slave
// Assumes: Bus pins and converter result come from outside the clock domain
// Notes: Open-drain pins drive low only, enable high while driving
//
// Behaviour
// - Convert every 100 ms, update reading
// - Converter active 10 ms per period
// - Shutdown stops conversions, bus stays alive
// - Settings bit 0 selects shutdown
// - Convert at power-up and leaving shutdown
// - Bus reads never disturb running conversion
// - Compare reading to limits after conversion
// - Nine-bit limits, compare top nine bits
// - Comparator: above limit asserts, below hysteresis clears
// - Comparator state unaffected by reads, shutdown
// - Interrupt: first trip on overtemperature, read clears
// - Interrupt trips alternate between both limits
// - Interrupt style: shutdown write clears alert
// - Alert needs queued consecutive faults
// - Settings bit 2 selects alert polarity
// - Settings bit 1 selects alert style
// - Power-up: normal, 80/75 limits, low, queue 1
// - No valid reading before first conversion
// - Data low past timeout returns bus idle
// - Slave address 1001 plus select pins
// - Select 0..3: reading, settings, hysteresis, limit
// - Reset values 00h, 4B00h, 5000h
// - Queue field 00/01/10/11 means 1/2/4/6
// - Writes latch select, reads reuse it
// - Reading left aligned, low five bits zero
`timescale 1ns/1ps
`include "tm_cfg.svh"

module tm_thermal_monitor import tm_pkg::*; #(
   parameter int CONV_PERIOD_CYC = `TM_CONV_PERIOD_CYC,
   parameter int CONV_TIME_CYC = `TM_CONV_TIME_CYC,
   parameter int BUS_TIMEOUT_CYC = `TM_BUS_TIMEOUT_CYC
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic addr_select_pin_2,
   input wire logic addr_select_pin_1,
   input wire logic addr_select_pin_0,
   input wire logic [10:0] adc_result,
   output logic conv_active,
   output logic alert_output,
   output logic alert_output_oe
);
   localparam int CW = $clog2(CONV_PERIOD_CYC + 1);
   localparam int TW = $clog2(BUS_TIMEOUT_CYC + 1);
   localparam logic [15:0] OS_RST = `TM_OS_RST;
   localparam logic [15:0] HYST_RST = `TM_HYST_RST;

   if (CONV_TIME_CYC < 1 || CONV_TIME_CYC >= CONV_PERIOD_CYC || BUS_TIMEOUT_CYC < 2) begin : g_chk
      $error("tm_thermal_monitor: bad timing parameters");
   end

   // Synchronisers, third stage only for edge detection
   logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
   logic [10:0] adc_m, adc_s;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_d <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_d <= 1'b1;
         adc_m <= 11'h000;
         adc_s <= 11'h000;
      end else if (clk_en) begin
         scl_m <= scl_in;
         scl_s <= scl_m;
         scl_d <= scl_s;
         sda_m <= sda_in;
         sda_s <= sda_m;
         sda_d <= sda_s;
         adc_m <= adc_result;
         adc_s <= adc_m;
      end
   end

   logic scl_rise, scl_fall, start_c, stop_c;
   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   assign start_c = scl_s & scl_d & ~sda_s & sda_d;
   assign stop_c = scl_s & scl_d & sda_s & ~sda_d;

   // Register file
   logic [7:0] settings;
   logic [8:0] os_lim, hyst_lim;
   logic [10:0] thermal_reading;
   logic shutdown, style_int, pol_high;
   assign shutdown = settings[`TM_SET_SHUTDOWN];
   assign style_int = settings[`TM_SET_STYLE];
   assign pol_high = settings[`TM_SET_POL];

   tm_bus_state_t st;
   logic [3:0] bit_cnt;
   logic [7:0] shreg, txsh;
   logic rw, byte_idx, nack, rd_start, wr_stb;
   tm_ptr_t ptr;
   logic [TW-1:0] to_cnt;
   logic bus_timeout;
   logic [6:0] own_addr;
   assign own_addr = {`TM_ADDR_FIXED, addr_select_pin_2, addr_select_pin_1,
                      addr_select_pin_0};

   function automatic logic [7:0] rd_byte(input tm_ptr_t p, input logic idx);
      logic [15:0] w;
      w = 16'h0000;
      case (p)
         `TM_PTR_TEMP: w = {thermal_reading, 5'h00};
         `TM_PTR_SET: w = {settings, settings};
         `TM_PTR_HYST: w = {hyst_lim, 7'h00};
         `TM_PTR_OS: w = {os_lim, 7'h00};
         default: w = 16'h0000;
      endcase
      return idx ? w[7:0] : w[15:8];
   endfunction : rd_byte

   function automatic logic [2:0] queue_need(input logic [1:0] q);
      case (q)
         2'h0: return 3'h1;
         2'h1: return 3'h2;
         2'h2: return 3'h4;
         default: return 3'h6;
      endcase
   endfunction : queue_need

   // Both bytes of the selected register, ready for the transmit path
   logic [7:0] rd_hi, rd_lo;
   assign rd_hi = rd_byte(ptr, 1'b0);
   assign rd_lo = rd_byte(ptr, 1'b1);

   // Stuck data line watchdog
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         to_cnt <= '0;
      end else if (clk_en) begin
         if (!sda_s && st != TM_IDLE && !bus_timeout) begin
            to_cnt <= to_cnt + 1'b1;
         end else begin
            to_cnt <= '0;
         end
      end
   end
   assign bus_timeout = (to_cnt == TW'(BUS_TIMEOUT_CYC - 1));

   assign sda_out = 1'b0;

   // Two-wire slave engine; master owns the clock
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st <= TM_IDLE;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         txsh <= 8'h00;
         rw <= 1'b0;
         byte_idx <= 1'b0;
         nack <= 1'b0;
         ptr <= `TM_PTR_TEMP;
         sda_oe <= 1'b0;
         rd_start <= 1'b0;
         wr_stb <= 1'b0;
      end else if (clk_en) begin
         rd_start <= 1'b0;
         wr_stb <= 1'b0;
         if (bus_timeout) begin
            st <= TM_IDLE;
            sda_oe <= 1'b0;
         end else if (start_c) begin
            st <= TM_ADDR;
            bit_cnt <= 4'h0;
            sda_oe <= 1'b0;
         end else if (stop_c) begin
            st <= TM_IDLE;
            sda_oe <= 1'b0;
         end else if (scl_rise) begin
            case (st)
               TM_ADDR, TM_WR_PTR, TM_WR_DATA: begin
                  shreg <= {shreg[6:0], sda_s};
                  bit_cnt <= bit_cnt + 4'h1;
               end
               TM_RD_ACK: nack <= sda_s;
               default: ;
            endcase
         end else if (scl_fall) begin
            case (st)
               TM_ADDR: begin
                  if (bit_cnt == 4'h8) begin
                     if (shreg[7:1] == own_addr) begin
                        st <= TM_ACK_ADDR;
                        sda_oe <= 1'b1;
                        rw <= shreg[0];
                     end else begin
                        st <= TM_IDLE;
                     end
                  end
               end
               TM_ACK_ADDR: begin
                  byte_idx <= 1'b0;
                  if (rw) begin
                     // Read reuses the latched select
                     st <= TM_RD_DATA;
                     sda_oe <= ~rd_hi[7];
                     txsh <= {rd_hi[6:0], 1'b0};
                     bit_cnt <= 4'h1;
                     rd_start <= 1'b1;
                  end else begin
                     st <= TM_WR_PTR;
                     sda_oe <= 1'b0;
                     bit_cnt <= 4'h0;
                  end
               end
               TM_RD_DATA: begin
                  if (bit_cnt == 4'h8) begin
                     sda_oe <= 1'b0;
                     st <= TM_RD_ACK;
                  end else begin
                     sda_oe <= ~txsh[7];
                     txsh <= {txsh[6:0], 1'b0};
                     bit_cnt <= bit_cnt + 4'h1;
                  end
               end
               TM_RD_ACK: begin
                  if (nack) begin
                     st <= TM_IDLE;
                  end else begin
                     byte_idx <= 1'b1;
                     st <= TM_RD_DATA;
                     sda_oe <= ~rd_lo[7];
                     txsh <= {rd_lo[6:0], 1'b0};
                     bit_cnt <= 4'h1;
                  end
               end
               TM_WR_PTR: begin
                  if (bit_cnt == 4'h8) begin
                     ptr <= shreg[1:0];
                     sda_oe <= 1'b1;
                     st <= TM_ACK_PTR;
                  end
               end
               TM_ACK_PTR: begin
                  sda_oe <= 1'b0;
                  st <= TM_WR_DATA;
                  bit_cnt <= 4'h0;
                  byte_idx <= 1'b0;
               end
               TM_WR_DATA: begin
                  if (bit_cnt == 4'h8) begin
                     wr_stb <= 1'b1;
                     sda_oe <= 1'b1;
                     st <= TM_ACK_WR;
                  end
               end
               TM_ACK_WR: begin
                  sda_oe <= 1'b0;
                  st <= TM_WR_DATA;
                  bit_cnt <= 4'h0;
                  byte_idx <= 1'b1;
               end
               default: st <= TM_IDLE;
            endcase
         end
      end
   end

   // Register writes
   logic set_wr;
   assign set_wr = wr_stb && ptr == `TM_PTR_SET && !byte_idx;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         settings <= `TM_SET_RST;
         os_lim <= OS_RST[15:7];
         hyst_lim <= HYST_RST[15:7];
      end else if (clk_en && wr_stb) begin
         case (ptr)
            `TM_PTR_SET: if (!byte_idx) settings <= shreg;
            `TM_PTR_HYST: begin
               if (!byte_idx) hyst_lim[8:1] <= shreg;
               else hyst_lim[0] <= shreg[7];
            end
            `TM_PTR_OS: begin
               if (!byte_idx) os_lim[8:1] <= shreg;
               else os_lim[0] <= shreg[7];
            end
            default: ; // Reading is read only
         endcase
      end
   end

   // Conversion scheduler, independent of bus traffic
   logic [CW-1:0] conv_cnt, next_conv_cnt;
   logic conv_done;
   always_comb begin
      if (shutdown || conv_cnt == CW'(CONV_PERIOD_CYC - 1)) next_conv_cnt = '0;
      else next_conv_cnt = conv_cnt + 1'b1;
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         conv_cnt <= '0;
         conv_active <= 1'b0;
         conv_done <= 1'b0;
         thermal_reading <= 11'h000;
      end else if (clk_en) begin
         conv_cnt <= next_conv_cnt;
         conv_active <= !shutdown && next_conv_cnt < CW'(CONV_TIME_CYC);
         conv_done <= 1'b0;
         if (!shutdown && conv_cnt == CW'(CONV_TIME_CYC - 1)) begin
            thermal_reading <= adc_s;
            conv_done <= 1'b1;
         end
      end
   end

   // Limit compare and alert
   logic [8:0] temp9;
   logic hot, cold, fault, fire, comp_active, int_latch, trip_hot, asserted;
   logic [2:0] fault_cnt;
   assign temp9 = thermal_reading[10:2];
   assign hot = $signed(temp9) > $signed(os_lim);
   assign cold = $signed(temp9) < $signed(hyst_lim);
   always_comb begin
      if (style_int) fault = !int_latch && (trip_hot ? hot : cold);
      else fault = comp_active ? cold : hot;
   end
   assign fire = fault && (fault_cnt + 3'h1 >= queue_need(settings[4:3]));
   assign asserted = style_int ? int_latch : comp_active;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         fault_cnt <= 3'h0;
      end else if (clk_en && conv_done && !shutdown) begin
         if (fault && !fire) fault_cnt <= fault_cnt + 3'h1;
         else fault_cnt <= 3'h0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         comp_active <= 1'b0;
      end else if (clk_en && conv_done && !shutdown && !style_int && fire) begin
         comp_active <= ~comp_active;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         int_latch <= 1'b0;
         trip_hot <= 1'b1;
      end else if (clk_en) begin
         if (conv_done && !shutdown && style_int && fire) begin
            int_latch <= 1'b1;
            trip_hot <= ~trip_hot;
         end else if (rd_start || (set_wr && style_int && shreg[0])) begin
            int_latch <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         alert_output <= 1'b1;
         alert_output_oe <= 1'b0;
      end else if (clk_en) begin
         alert_output <= ~(asserted ^ pol_high);
         alert_output_oe <= asserted ^ pol_high;
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   a_conv_update: assert property (clk_en && conv_done |=> thermal_reading == $past(adc_s))
      else $error("reading not taken at conversion end");
   a_conv_active_win: assert property (clk_en && !shutdown && conv_cnt == '0 |=> conv_active)
      else $error("converter not active at period start");
   a_shutdown_idle: assert property (shutdown |=> !conv_done && conv_cnt == '0)
      else $error("conversion while shut down");
   a_read_no_stall: assert property (clk_en && rd_start && !shutdown
      && conv_cnt < CW'(CONV_PERIOD_CYC - 1) |=> conv_cnt == $past(conv_cnt) + 1'b1)
      else $error("bus read disturbed conversion");
   a_addr_match: assert property (clk_en && !bus_timeout && !start_c && !stop_c && scl_fall
      && st == TM_ADDR && bit_cnt == 4'h8 && shreg[7:1] == own_addr
      |=> st == TM_ACK_ADDR && sda_oe)
      else $error("own address not acknowledged");
   a_queue_gate: assert property (clk_en && $rose(comp_active)
      |-> $past(fault_cnt) + 3'h1 >= $past(queue_need(settings[4:3])))
      else $error("alert before fault queue met");
   a_int_read_clr: assert property (clk_en && rd_start && !(conv_done && style_int && fire)
      |=> !int_latch)
      else $error("read did not clear interrupt alert");
   a_timeout_idle: assert property (clk_en && bus_timeout |=> st == TM_IDLE && !sda_oe)
      else $error("stuck line did not release bus");
   a_ptr_latch: assert property (clk_en && !bus_timeout && !start_c && !stop_c && scl_fall
      && st == TM_WR_PTR && bit_cnt == 4'h8 |=> ptr == $past(shreg[1:0]))
      else $error("register select not latched");
   a_reset_vals: assert property ($fell(sys_rst) |-> settings == 8'h00
      && os_lim == 9'h0a0 && hyst_lim == 9'h096)
      else $error("wrong reset register values");
   a_polarity: assert property (clk_en ##1 1'b1 |-> alert_output == (pol_high ? $past(asserted)
      : !$past(asserted)) || $changed(settings))
      else $error("alert polarity wrong");
endmodule : tm_thermal_monitor

// ==== sim/tm_bus_master.sv ====
// Purpose: Two-wire bus master model driving the serial clock and data line
// Assumes: Data line has a pull-up; this model only pulls it low
// Notes: A bit takes four quarters of four system clocks, so each clock half is 8 clocks
`timescale 1ns/1ps

module tm_bus_master (
   input wire logic sys_clk,
   input wire logic sda_line,
   output logic scl,
   output logic sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic quarter;
      repeat (4) @(posedge sys_clk);
      #1;
   endtask : quarter

   // Master makes every clock pulse and owns the data line except in answers
   task automatic bit_io(input logic b, output logic r);
      quarter();
      sda_low = ~b;
      quarter();
      scl = 1'b1;
      quarter();
      r = sda_line;
      quarter();
      scl = 1'b0;
   endtask : bit_io

   task automatic begin_frame;
      quarter();
      sda_low = 1'b0;
      quarter();
      scl = 1'b1;
      quarter();
      sda_low = 1'b1;
      quarter();
      scl = 1'b0;
   endtask : begin_frame

   task automatic end_frame;
      quarter();
      sda_low = 1'b1;
      quarter();
      scl = 1'b1;
      quarter();
      sda_low = 1'b0;
      quarter();
   endtask : end_frame

   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], r);
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask : put_byte

   // Last byte of a read is refused so the device lets go of the line
   task automatic get_byte(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, b[i]);
      end
      bit_io(last, r);
   endtask : get_byte
endmodule : tm_bus_master

// ==== sim/tb.sv ====
// Purpose: Self-checking bench for the thermal monitor and alert control block
// Assumes: Shortened counts 400/40/300 cycles, address pins static
// Notes: Converter input changes just after a conversion ends or as a conversion starts
`timescale 1ns/1ps
`include "tm_cfg.svh"

module tb import tm_pkg::*;;
   localparam int PER = 400;
   localparam int CT = 40;
   localparam int TO = 300;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic clk_en = 1'b1;
   logic scl, sda_low, sda_line, sda_out, sda_oe, conv_active, alert_output, alert_output_oe;
   logic [2:0] pins = 3'b000;
   logic [10:0] adc = 11'h100;
   logic [31:0] rnd = 32'h1036;
   logic [15:0] d;
   logic pol = 1'b0;
   logic ack;
   int n;
   int cyc = 0;
   int miscompares = 0;
   int tests_run = 0;

   assign sda_line = (sda_oe === 1'b1 || sda_low === 1'b1) ? 1'b0 : 1'b1;

   tm_thermal_monitor #(.CONV_PERIOD_CYC(PER), .CONV_TIME_CYC(CT), .BUS_TIMEOUT_CYC(TO))
      i_tm_thermal_monitor (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
      .addr_select_pin_2(pins[2]), .addr_select_pin_1(pins[1]), .addr_select_pin_0(pins[0]),
      .adc_result(adc), .conv_active(conv_active), .alert_output(alert_output),
      .alert_output_oe(alert_output_oe));

   tm_bus_master i_tm_bus_master (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl),
      .sda_low(sda_low));

   initial begin
      forever #25 sys_clk = ~sys_clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr

   task automatic stop_test;
      $display("checks %0d, wrong %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic act(input logic on);
      chk({14'h0, alert_output, alert_output_oe}, on ? {14'h0, pol, ~pol} : {14'h0, ~pol, pol});
   endtask : act

   task automatic do_reset;
      sys_rst = 1'b1;
      adc = 11'h100;
      pol = 1'b0;
      repeat (20) @(posedge sys_clk);
      #1;
      sys_rst = 1'b0;
   endtask : do_reset

   task automatic run_len(input logic lvl, output int k);
      k = 0;
      while (conv_active === lvl && k < 2 * PER) begin
         @(posedge sys_clk);
         #1;
         k++;
      end
   endtask : run_len

   task automatic wait_conv(input int cnt);
      int k;
      repeat (cnt) begin
         run_len(1'b0, k);
         run_len(1'b1, k);
         repeat (4) @(posedge sys_clk);
         #1;
      end
   endtask : wait_conv

   task automatic wr(input tm_ptr_t p, input logic [15:0] v, input int nb);
      logic a;
      i_tm_bus_master.begin_frame();
      i_tm_bus_master.put_byte({`TM_ADDR_FIXED, pins, 1'b0}, a);
      chk({15'h0, a}, 16'h0001);
      i_tm_bus_master.put_byte({6'h00, p}, a);
      chk({15'h0, a}, 16'h0001);
      for (int i = 0; i < nb; i++) begin
         i_tm_bus_master.put_byte(i == 0 ? v[15:8] : v[7:0], a);
      end
      i_tm_bus_master.end_frame();
   endtask : wr

   task automatic rd(input tm_ptr_t p, input logic sel, output logic [15:0] v);
      logic a;
      logic [7:0] b0, b1;
      if (sel) begin
         i_tm_bus_master.begin_frame();
         i_tm_bus_master.put_byte({`TM_ADDR_FIXED, pins, 1'b0}, a);
         i_tm_bus_master.put_byte({6'h00, p}, a);
      end
      i_tm_bus_master.begin_frame();
      i_tm_bus_master.put_byte({`TM_ADDR_FIXED, pins, 1'b1}, a);
      chk({15'h0, a}, 16'h0001);
      i_tm_bus_master.get_byte(1'b0, b0);
      i_tm_bus_master.get_byte(1'b1, b1);
      i_tm_bus_master.end_frame();
      v = {b0, b1};
   endtask : rd

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 100000) begin
         miscompares++;
         stop_test();
      end
   end

   initial begin
      rnd = lfsr(rnd);
      pins = rnd[2:0];
      do_reset();
      act(1'b0);
      rd(1, 1'b1, d);
      chk(d, 16'h0000);
      rd(2, 1'b1, d);
      chk(d, 16'h4b00);
      rd(3, 1'b1, d);
      chk(d, 16'h5000);
      rd(3, 1'b0, d);
      chk(d, 16'h5000);
      for (int p = 2; p < 4; p++) begin
         rnd = lfsr(rnd);
         wr(tm_ptr_t'(p), rnd[15:0], 2);
         rd(tm_ptr_t'(p), 1'b0, d);
         chk(d, {rnd[15:7], 7'h00});
      end
      wr(0, 16'hffff, 2);
      rd(0, 1'b0, d);
      chk(d, {adc, 5'h00});
      i_tm_bus_master.begin_frame();
      i_tm_bus_master.put_byte({`TM_ADDR_FIXED, ~pins, 1'b1}, ack);
      i_tm_bus_master.end_frame();
      chk({15'h0, ack}, 16'h0000);
      $display("done: registers");
      // Timing measured while a read runs across conversions
      do_reset();
      for (int i = 0; i < 3; i++) begin
         rnd = lfsr(rnd);
         adc = rnd[10:0];
         wait_conv(1);
         fork
            rd(0, 1'b0, d);
            begin
               run_len(1'b0, n);
               run_len(1'b1, n);
               chk(16'(n), 16'(CT));
               run_len(1'b0, n);
               chk(16'(n), 16'(PER - CT));
            end
         join
         chk(d, {adc, 5'h00});
      end
      $display("done: conversion");
      do_reset();
      adc = {9'h0a0, 2'b11};
      wait_conv(2);
      act(1'b0);
      adc = {9'h0a1, 2'b00};
      wait_conv(1);
      act(1'b1);
      adc = {9'h096, 2'b00};
      wait_conv(2);
      act(1'b1);
      rd(0, 1'b1, d);
      act(1'b1);
      wr(1, 16'h0100, 1);
      act(1'b1);
      adc = 11'h050;
      run_len(1'b0, n);
      chk(16'(n), 16'(2 * PER));
      rd(0, 1'b1, d);
      chk(d, {9'h096, 2'b00, 5'h00});
      wr(1, 16'h0000, 1);
      rd(0, 1'b1, d);
      chk(d, {11'h050, 5'h00});
      act(1'b0);
      for (int q = 0; q < 4; q++) begin
         pol = q[0];
         wr(1, {3'b000, q[1:0], pol, 2'b00, 8'h00}, 1);
         adc = 11'h100;
         wait_conv(7);
         act(1'b0);
         adc = 11'h300;
         n = 0;
         while (alert_output !== pol && n < 8) begin
            wait_conv(1);
            n++;
         end
         chk(16'(n), (q == 0) ? 16'h0001 : 16'(2 * q));
      end
      $display("done: comparator");
      do_reset();
      wr(1, 16'h0200, 1);
      adc = 11'h300;
      wait_conv(1);
      act(1'b1);
      wait_conv(2);
      act(1'b1);
      rd(1, 1'b0, d);
      act(1'b0);
      wait_conv(2);
      act(1'b0);
      adc = 11'h100;
      wait_conv(1);
      act(1'b1);
      wr(1, 16'h0300, 1);
      act(1'b0);
      $display("done: interrupt");
      do_reset();
      rd(3, 1'b1, d);
      i_tm_bus_master.begin_frame();
      i_tm_bus_master.put_byte({`TM_ADDR_FIXED, pins, 1'b1}, ack);
      repeat (8) @(posedge sys_clk);
      #1;
      chk({15'h0, sda_oe}, 16'h0001);
      chk({15'h0, sda_out}, 16'h0000);
      repeat (TO + 20) @(posedge sys_clk);
      #1;
      chk({15'h0, sda_oe}, 16'h0000);
      i_tm_bus_master.end_frame();
      rd(3, 1'b0, d);
      chk(d, 16'h5000);
      $display("done: bus timeout");
      stop_test();
   end
endmodule : tb
